// file: src/adc_conversion_readout.sv
// Summary of operation
// [R1] Converts continuously from reset without commands
// [R2] Completion clears ready, drives line low
// [R3] Host writes read command before data
// [R4] Line high after read; rereads allowed
// [R5] Result dropped while a read runs
// [R6] Loop enabled channels, update each result
// [R7] Ready per result, read during next
// [R8] Status byte appended when enabled
// [R9] Command 01011100 enters continuous read
// [R10] Continuous read outputs result on clocks
// [R11] Host sets continuous conversion first
// [R12] Continuous read: one read per result
// [R13] Unread result replaced at next completion
// [R14] Command 01011000 exits while ready low
// [R15] Forty ones on data in resets all
// [R16] Host holds data in low idle
// [R17] Unipolar output straight binary
// [R18] Bipolar output offset binary
// [R19] Three-bit code selects gain
// [R20] Two-bit field selects clock source
// [R21] Buffer enable routes input path
// [R22] Polarity bit selects output format
// [R23] Every access starts with command write
// [R24] Host waits after ones reset
// [R25] Line high before data update; code gives no high pulse when an unread result is replaced
// [R26] MSB first, status after word
//
// Serial readout side of a sigma-delta converter. The modulator is
// outside: it presents raw signed samples with a done strobe on CORE_CLK.
// SCLK, CS_N and DIN come from the host and are synchronised here.
`timescale 1ns/1ps
module adc_conversion_readout
    import adc_readout_pkg::*;
#(
    parameter int RESULT_W = `RESULT_BITS
) (
    input wire logic CORE_CLK, // 100 MHz core clock
    input wire logic RST_N, // Sync reset, active low
    input wire logic SCLK, // Host serial clock
    input wire logic CS_N, // Chip select, active low
    input wire logic DIN, // Host serial data
    output logic DOUT_RDY_N, // Data out and ready, active low
    input wire logic CONV_DONE, // Modulator result strobe
    input wire logic [RESULT_W-1:0] CONV_RAW, // Signed two's complement result
    input wire logic [`CHAN_COUNT-1:0] CHAN_ENABLE, // Enabled channels
    input wire logic APPEND_STATUS_ENABLE, // Append status byte
    input wire logic POLARITY_SELECT, // 1 unipolar, 0 bipolar
    input wire logic INPUT_BUFFER_ENABLE, // Buffered input path
    input wire adc_readout_pkg::gain_t GAIN_SELECT, // Gain code
    input wire adc_readout_pkg::clk_src_t CLOCK_SOURCE_SELECT, // Clock source
    output logic [`CHAN_BITS-1:0] ACTIVE_CHANNEL, // Channel now converting
    output logic [7:0] GAIN_VALUE, // Decoded gain
    output logic BUFFER_ON, // Buffer amplifier in path
    output logic EXT_CLOCK_USED, // External clock selected
    output logic MASTER_CLOCK_PIN2_EN, // Internal clock driven out
    output logic CONT_READ, // Continuous read mode active
    output logic [7:0] STATUS // Status register
);
    import adc_readout_pkg::*;

    localparam int FRAME_W = RESULT_W + `STATUS_BITS;

    logic [2:0] sclk_sync_ff;
    logic [1:0] cs_sync_ff;
    logic [1:0] din_sync_ff;
    logic sclk_rise, sclk_fall, cs_low, din_s;
    // Two flops per pin, third tap only for SCLK edge finding
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            sclk_sync_ff <= 3'h7;
            cs_sync_ff <= 2'h3;
            din_sync_ff <= 2'h0;
        end else begin
            sclk_sync_ff <= {sclk_sync_ff[1:0], SCLK};
            cs_sync_ff <= {cs_sync_ff[0], CS_N};
            din_sync_ff <= {din_sync_ff[0], DIN};
        end
    end
    assign sclk_rise = sclk_sync_ff[1] && !sclk_sync_ff[2];
    assign sclk_fall = !sclk_sync_ff[1] && sclk_sync_ff[2];
    assign cs_low = !cs_sync_ff[1];
    assign din_s = din_sync_ff[1];

    logic ones_reset;
    logic soft_rst;
    assign soft_rst = !RST_N || ones_reset;

    // Front end decode kept apart from the serial path
    adc_gain_decode u_decode (
        .CORE_CLK(CORE_CLK),
        .RST_N(!soft_rst),
        .gain_select(GAIN_SELECT),
        .clock_source_select(CLOCK_SOURCE_SELECT),
        .gain_value(GAIN_VALUE),
        .gain_valid(),
        .ext_clock_used(EXT_CLOCK_USED),
        .mclk_out_en(MASTER_CLOCK_PIN2_EN)
    );

    // [R21] buffer path select
    always_ff @(posedge CORE_CLK) begin
        if (soft_rst) BUFFER_ON <= 1'b0;
        else BUFFER_ON <= INPUT_BUFFER_ENABLE;
    end

    // [R15] forty ones reset
    logic [5:0] ones_cnt_ff;
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N || ones_reset) begin
            ones_cnt_ff <= 6'h00;
        end else if (sclk_rise && cs_low) begin
            if (!din_s) ones_cnt_ff <= 6'h00;
            else ones_cnt_ff <= ones_cnt_ff + 6'h01;
        end
    end
    assign ones_reset = (ones_cnt_ff == `ONES_RESET_COUNT);

    // [R6] step through enabled channels
    function automatic chan_t next_chan(input chan_t cur, input logic [`CHAN_COUNT-1:0] en);
        chan_t c;
        c = cur;
        for (int i = 1; i <= `CHAN_COUNT; i++) begin
            c = chan_t'(cur + chan_t'(i));
            if (en[c]) return c;
        end
        return cur;
    endfunction

    // [R17] [R18] [R22] straight or offset binary
    result_t coded;
    assign coded = POLARITY_SELECT ? CONV_RAW : {~CONV_RAW[RESULT_W-1], CONV_RAW[RESULT_W-2:0]};

    serial_state_e state_ff;
    logic [7:0] cmd_ff;
    logic [2:0] cmd_bits_ff;
    logic [FRAME_W-1:0] shift_ff;
    logic [5:0] shift_cnt_ff;
    logic [5:0] frame_len;
    result_t data_ff;
    chan_t data_chan_ff;
    logic rdy_n_ff, lead_rdy_ff, reading;
    assign frame_len = APPEND_STATUS_ENABLE ? 6'(FRAME_W) : 6'(RESULT_W);
    assign reading = (state_ff == ST_SHIFT);

    // [R1] continuous conversion from reset
    // [R6] channel sequence on each done
    always_ff @(posedge CORE_CLK) begin
        if (soft_rst) ACTIVE_CHANNEL <= '0;
        else if (CONV_DONE) ACTIVE_CHANNEL <= next_chan(ACTIVE_CHANNEL, CHAN_ENABLE);
    end

    // [R5] drop result while command read runs
    // [R13] continuous read reloads on completion
    logic accept;
    assign accept = CONV_DONE && (CONT_READ || !reading);
    always_ff @(posedge CORE_CLK) begin
        if (soft_rst) begin
            data_ff <= '0;
            data_chan_ff <= '0;
        end else if (accept) begin
            data_ff <= coded;
            data_chan_ff <= ACTIVE_CHANNEL;
        end
    end

    // [R2] ready flag and status contents
    // [R8] channel in low status bits
    always_ff @(posedge CORE_CLK) begin
        if (soft_rst) STATUS <= 8'h80;
        else begin
            STATUS[`STATUS_READY_BIT] <= rdy_n_ff;
            STATUS[6:0] <= 7'(data_chan_ff);
        end
    end

    // Serial engine: command capture, shifting, continuous read
    always_ff @(posedge CORE_CLK) begin
        if (soft_rst || !cs_low) begin
            state_ff <= ST_CMD;
            cmd_bits_ff <= 3'h0;
            cmd_ff <= 8'h00;
            shift_cnt_ff <= 6'h00;
            if (soft_rst) begin
                CONT_READ <= 1'b0;
                shift_ff <= '0;
            end
        end else begin
            case (state_ff)
                ST_CMD: begin
                    if (CONT_READ && accept) begin
                        // [R10] auto load result
                        // [R26] MSB first, status after
                        shift_ff <= {coded, 1'b0, 7'(ACTIVE_CHANNEL)};
                        shift_cnt_ff <= 6'h00;
                        state_ff <= ST_SHIFT;
                        // Command bits realigned to the frame start
                        cmd_bits_ff <= 3'h0;
                    end else if (sclk_rise) begin
                        cmd_ff <= {cmd_ff[6:0], din_s};
                        cmd_bits_ff <= cmd_bits_ff + 3'h1;
                        if (cmd_bits_ff == 3'h7) begin
                            // [R9] enter continuous read
                            if ({cmd_ff[6:0], din_s} == `CMD_CONT_READ_ENTER) begin
                                CONT_READ <= 1'b1;
                            // [R14] exit when ready low
                            end else if (CONT_READ && !rdy_n_ff &&
                                         {cmd_ff[6:0], din_s} == `CMD_CONT_READ_EXIT) begin
                                CONT_READ <= 1'b0;
                            // [R3] [R23] data read command
                            end else if (!CONT_READ &&
                                         {cmd_ff[6:0], din_s} == `CMD_READ_DATA) begin
                                // [R4] reread of held data
                                shift_ff <= {data_ff, 1'b0, 7'(data_chan_ff)};
                                shift_cnt_ff <= 6'h00;
                                state_ff <= ST_SHIFT;
                            end
                        end
                    end
                end
                ST_SHIFT: begin
                    if (CONT_READ && accept) begin
                        // [R13] reset output register
                        shift_ff <= {coded, 1'b0, 7'(ACTIVE_CHANNEL)};
                        shift_cnt_ff <= 6'h00;
                        cmd_bits_ff <= 3'h0;
                    end else if (sclk_rise) begin
                        shift_ff <= {shift_ff[FRAME_W-2:0], 1'b0};
                        shift_cnt_ff <= shift_cnt_ff + 6'h01;
                        if (shift_cnt_ff + 6'h01 == frame_len) state_ff <= ST_CMD;
                        // [R14] exit watched while a result is pending
                        // Host sends the exit byte instead of reading the word
                        if (CONT_READ) begin
                            cmd_ff <= {cmd_ff[6:0], din_s};
                            cmd_bits_ff <= cmd_bits_ff + 3'h1;
                            if (cmd_bits_ff == 3'h7 && !rdy_n_ff &&
                                {cmd_ff[6:0], din_s} == `CMD_CONT_READ_EXIT) begin
                                CONT_READ <= 1'b0;
                                state_ff <= ST_CMD;
                            end
                        end
                    end
                end
                default: state_ff <= ST_CMD;
            endcase
        end
    end

    // [R2] [R7] [R12] [R25] ready flag
    always_ff @(posedge CORE_CLK) begin
        if (soft_rst) rdy_n_ff <= 1'b1;
        else if (accept) rdy_n_ff <= 1'b0;
        else if (reading && sclk_rise && shift_cnt_ff + 6'h01 == frame_len) rdy_n_ff <= 1'b1;
        else if (CONV_DONE) rdy_n_ff <= 1'b1;
    end

    // [R10] ready low stands until the first falling clock
    // Without it a result with MSB set would never show ready
    always_ff @(posedge CORE_CLK) begin
        if (soft_rst || !cs_low) lead_rdy_ff <= 1'b0;
        else if (CONT_READ && accept) lead_rdy_ff <= 1'b1;
        else if (sclk_fall) lead_rdy_ff <= 1'b0;
    end

    // Pin mux: data while shifting, else ready level
    always_ff @(posedge CORE_CLK) begin
        if (soft_rst) DOUT_RDY_N <= 1'b1;
        else if (!cs_low) DOUT_RDY_N <= 1'b1;
        else if (reading && lead_rdy_ff && !sclk_fall) DOUT_RDY_N <= 1'b0;
        else if (reading && !(sclk_rise && shift_cnt_ff + 6'h01 == frame_len))
            DOUT_RDY_N <= shift_ff[FRAME_W-1];
        else DOUT_RDY_N <= rdy_n_ff && !accept;
    end

    // [R1] starts in continuous conversion
    a_reset_mode: assert property (@(posedge CORE_CLK)
        $rose(RST_N) |-> !CONT_READ && rdy_n_ff) // [R1]
        else $error("not idle after reset");
    // [R2] ready low after a completion
    a_ready_low: assert property (@(posedge CORE_CLK) disable iff (soft_rst)
        accept |=> !rdy_n_ff ##1 !STATUS[`STATUS_READY_BIT]) // [R2]
        else $error("ready not low after result");
    // [R5] held data kept during read
    a_drop_busy: assert property (@(posedge CORE_CLK) disable iff (soft_rst)
        CONV_DONE && reading && !CONT_READ |=> $stable(data_ff)) // [R5]
        else $error("result stored during read");
    // [R9] enter command sets mode
    sequence s_cmd_byte;
        cs_low && sclk_rise && state_ff == ST_CMD && cmd_bits_ff == 3'h7 && !accept;
    endsequence
    a_enter_cread: assert property (@(posedge CORE_CLK) disable iff (soft_rst)
        s_cmd_byte and ({cmd_ff[6:0], din_s} == `CMD_CONT_READ_ENTER) |=> CONT_READ) // [R9]
        else $error("continuous read not entered");
    // [R14] exit honoured only with ready low
    a_exit_cread: assert property (@(posedge CORE_CLK) disable iff (soft_rst)
        CONT_READ && rdy_n_ff |=> CONT_READ || !cs_low || $past(cmd_bits_ff) != 3'h7) // [R14]
        else $error("left continuous read while ready high");
    // [R15] ones count resets mode
    a_ones_reset: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        ones_reset |=> !CONT_READ && ones_cnt_ff == 6'h00) // [R15]
        else $error("ones reset not taken");
    // [R4] line high after full read
    a_read_done: assert property (@(posedge CORE_CLK) disable iff (soft_rst)
        reading && sclk_rise && cs_low && shift_cnt_ff + 6'h01 == frame_len && !CONV_DONE
        |=> rdy_n_ff ##1 DOUT_RDY_N) // [R4]
        else $error("ready not released after read");
    // [R18] bipolar code flips sign bit
    a_offset_code: assert property (@(posedge CORE_CLK) disable iff (soft_rst)
        !POLARITY_SELECT |-> coded[RESULT_W-1] != CONV_RAW[RESULT_W-1]) // [R18]
        else $error("offset binary wrong");
    // [R10] ready low held before the first bit
    a_lead_ready: assert property (@(posedge CORE_CLK) disable iff (soft_rst)
        lead_rdy_ff && reading && cs_low && !sclk_fall |=> !DOUT_RDY_N) // [R10]
        else $error("ready low not held in continuous read");
endmodule

// file: src/adc_gain_decode.sv
// Gain and clock source decode for the analog front end controls.
// Assumes static configuration inputs on the core clock.
`timescale 1ns/1ps
module adc_gain_decode
    import adc_readout_pkg::*;
(
    input wire logic CORE_CLK, // Core clock
    input wire logic RST_N, // Sync reset, active low
    input wire adc_readout_pkg::gain_t gain_select, // Gain code
    input wire adc_readout_pkg::clk_src_t clock_source_select, // Clock source
    output logic [7:0] gain_value, // Decoded amplifier gain
    output logic gain_valid, // Code is a legal gain
    output logic ext_clock_used, // Crystal or external clock
    output logic mclk_out_en // Drive internal clock out
);
    // Registered decode keeps analog controls glitch free
    // [R19] gain from code
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            gain_value <= 8'h01;
            gain_valid <= 1'b1;
        end else begin
            gain_valid <= 1'b1;
            case (gain_select)
                `GAIN_1: gain_value <= 8'h01;
                `GAIN_8: gain_value <= 8'h08;
                `GAIN_16: gain_value <= 8'h10;
                `GAIN_32: gain_value <= 8'h20;
                `GAIN_64: gain_value <= 8'h40;
                `GAIN_128: gain_value <= 8'h80;
                default: begin
                    gain_value <= 8'h01;
                    gain_valid <= 1'b0;
                end
            endcase
        end
    end
    // [R20] clock source select
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            ext_clock_used <= 1'b0;
            mclk_out_en <= 1'b0;
        end else begin
            ext_clock_used <= (clock_source_select == `CLK_SRC_CRYSTAL) ||
                              (clock_source_select == `CLK_SRC_EXTERNAL);
            mclk_out_en <= (clock_source_select == `CLK_SRC_INT_OUT);
        end
    end
endmodule

// file: src/adc_readout_cfg.svh
// Constants for the converter readout block: commands, widths, counts, codes.
// Assumes inclusion by bare name from package and design files.
`ifndef ADC_READOUT_CFG_SVH
`define ADC_READOUT_CFG_SVH
`define CMD_CONT_READ_ENTER 8'h5c
`define CMD_CONT_READ_EXIT 8'h58
`define CMD_READ_DATA 8'h58
`define RESULT_BITS 24
`define STATUS_BITS 8
`define ONES_RESET_COUNT 6'h28
`define CHAN_COUNT 4
`define CHAN_BITS 2
`define CLK_SRC_INTERNAL 2'h0
`define CLK_SRC_INT_OUT 2'h1
`define CLK_SRC_CRYSTAL 2'h2
`define CLK_SRC_EXTERNAL 2'h3
`define GAIN_1 3'h0
`define GAIN_8 3'h3
`define GAIN_16 3'h4
`define GAIN_32 3'h5
`define GAIN_64 3'h6
`define GAIN_128 3'h7
`define STATUS_READY_BIT 7
`endif

// file: src/adc_readout_pkg.sv
// Types shared by the converter readout design.
// Assumes the cfg header defines all numeric constants.
`include "adc_readout_cfg.svh"
package adc_readout_pkg;
    typedef logic [`RESULT_BITS-1:0] result_t;
    typedef logic [`CHAN_BITS-1:0] chan_t;
    typedef logic [2:0] gain_t;
    typedef logic [1:0] clk_src_t;
    typedef enum logic [1:0] {
        ST_CMD = 2'b00,
        ST_SHIFT = 2'b01,
        ST_SKIP = 2'b10
    } serial_state_e;
endpackage

// file: testbench/adc_conversion_readout_tb.sv
// Self-checking bench for the converter readout block.
// Assumes the host model above and channels 0 and 2 enabled, except channels 1 and 3 for two results.
`timescale 1ns/1ps
`include "adc_readout_cfg.svh"
`define CHECK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("Error t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
        end \
    end
module adc_conversion_readout_tb;
    import adc_readout_pkg::*;
    logic core_clk = 1'b0, rst_n, conv_done, append, pol;
    logic buf_en, sclk, cs_n, din, dout_rdy_n, buffer_on, ext_clk, mclk_en, cont_read;
    result_t conv_raw;
    logic [3:0] chan_en;
    gain_t gain_sel;
    clk_src_t clk_src;
    logic [1:0] active_ch, res_ch, exp_ch = 2'h0;
    logic [7:0] gain_value, status;
    logic [31:0] w;
    int num_errors = 0, num_checks = 0;
    // Codes 1 and 2 are unused and fall back to unity gain
    gain_t gcode [8] = '{`GAIN_1, `GAIN_8, `GAIN_16, `GAIN_32, `GAIN_64, `GAIN_128, 3'h1, 3'h2};
    logic [7:0] gval [8] = '{8'h01, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'h01, 8'h01};

    // 100 MHz core clock
    always #5 core_clk = ~core_clk;

    adc_conversion_readout adc_conversion_readout_inst (.CORE_CLK(core_clk), .RST_N(rst_n),
        .SCLK(sclk), .CS_N(cs_n), .DIN(din), .DOUT_RDY_N(dout_rdy_n), .CONV_DONE(conv_done),
        .CONV_RAW(conv_raw), .CHAN_ENABLE(chan_en), .APPEND_STATUS_ENABLE(append),
        .POLARITY_SELECT(pol), .INPUT_BUFFER_ENABLE(buf_en), .GAIN_SELECT(gain_sel),
        .CLOCK_SOURCE_SELECT(clk_src), .ACTIVE_CHANNEL(active_ch), .GAIN_VALUE(gain_value),
        .BUFFER_ON(buffer_on), .EXT_CLOCK_USED(ext_clk), .MASTER_CLOCK_PIN2_EN(mclk_en),
        .CONT_READ(cont_read), .STATUS(status));

    host_serial_model host_serial_model_inst (.sclk(sclk), .cs_n(cs_n), .din(din),
        .dout_rdy_n(dout_rdy_n));

    // Verdict and end of run
    task automatic wrap_up();
        $display("Checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Expected output code from the raw sample
    function automatic result_t fmt(input result_t r);
        return pol ? r : {~r[23], r[22:0]};
    endfunction

    task automatic conv(input result_t raw);
        int k;
        @(negedge core_clk);
        conv_done = 1'b1;
        conv_raw = raw;
        @(negedge core_clk);
        conv_done = 1'b0;
        // Result belongs to the old channel; search onward for the next enabled one
        res_ch = exp_ch;
        k = 1;
        while (k < 4 && !chan_en[2'(res_ch + k)])
            k++;
        exp_ch = 2'(res_ch + k);
        repeat (2) @(negedge core_clk);
        `CHECK(active_ch, exp_ch); // next channel
    endtask

    // Bounded wait for the ready level
    task automatic wait_rdy();
        int n;
        for (n = 0; n < 50 && dout_rdy_n !== 1'b0; n++)
            @(negedge core_clk);
        if (n == 50) begin
            num_errors++;
            $display("Error t=%0t ready never low", $time);
            wrap_up();
        end
    endtask

    task automatic cmd_read(input int n, output logic [31:0] rw);
        host_serial_model_inst.send_byte(8'h58);
        host_serial_model_inst.read_word(n, rw);
    endtask

    // Hang guard
    initial begin
        #900us;
        num_errors++;
        wrap_up();
    end

    initial begin
        rst_n = 1'b0;
        conv_done = 1'b0;
        conv_raw = '0;
        append = 1'b0;
        pol = 1'b0;
        buf_en = 1'b0;
        chan_en = 4'h5;
        gain_sel = `GAIN_1;
        clk_src = `CLK_SRC_INTERNAL;
        repeat (16) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        `CHECK({dout_rdy_n, cont_read, status}, {2'b10, 8'h80}); // reset levels
        // Front end selections through every code
        for (int i = 0; i < 8; i++) begin
            gain_sel = gcode[i];
            repeat (2) @(negedge core_clk);
            `CHECK(gain_value, gval[i]); // gain table
        end
        for (int i = 0; i < 4; i++) begin
            clk_src = clk_src_t'(i);
            buf_en = i[0];
            repeat (2) @(negedge core_clk);
            `CHECK({ext_clk, mclk_en}, {i >= 2, i == 1}); // clock source
            `CHECK(buffer_on, i[0]); // buffer path
        end
        host_serial_model_inst.select(1'b1);
        // Free-running result, bipolar, then reread
        conv(24'h123456);
        wait_rdy(); // no command needed
        `CHECK(status[7], 1'b0); // ready bit clear
        cmd_read(24, w);
        `CHECK(w[23:0], fmt(24'h123456)); // offset binary
        repeat (5) @(negedge core_clk);
        `CHECK(dout_rdy_n, 1'b1); // high after read
        cmd_read(24, w);
        `CHECK(w[23:0], fmt(24'h123456)); // same word again
        pol = 1'b1;
        chan_en = 4'ha; // Channels 1 and 3 only
        conv(24'h0000ff);
        wait_rdy(); // one pulse per result
        cmd_read(24, w);
        `CHECK(w[23:0], 24'h0000ff); // straight binary
        // Status byte after the word, channel of the held result
        append = 1'b1;
        conv(24'h0a0b0c);
        wait_rdy();
        cmd_read(32, w);
        `CHECK(w, {24'h0a0b0c, 6'h00, res_ch}); // status
        append = 1'b0;
        chan_en = 4'h5;
        // Result arriving mid read is lost
        conv(24'h111111);
        wait_rdy();
        fork
            cmd_read(24, w);
            begin
                #2000;
                conv(24'h222222);
            end
        join
        `CHECK(w[23:0], 24'h111111); // read unharmed
        cmd_read(24, w);
        `CHECK(w[23:0], 24'h111111); // newer result dropped
        host_serial_model_inst.send_byte(8'h5c);
        repeat (5) @(negedge core_clk);
        `CHECK(cont_read, 1'b1); // mode entered
        conv(24'h345678);
        wait_rdy();
        host_serial_model_inst.read_word(24, w);
        `CHECK(w[23:0], 24'h345678); // clocks only
        repeat (20) @(negedge core_clk);
        `CHECK(dout_rdy_n, 1'b1); // high until next result
        host_serial_model_inst.send_byte(8'h58);
        repeat (5) @(negedge core_clk);
        `CHECK(cont_read, 1'b1); // exit refused while ready high
        conv(24'hffffff);
        wait_rdy();
        host_serial_model_inst.read_word(8, w);
        conv(24'h5a5a5a);
        wait_rdy();
        host_serial_model_inst.read_word(24, w);
        `CHECK(w[23:0], 24'h5a5a5a); // partial word replaced
        conv(24'h000000);
        wait_rdy();
        host_serial_model_inst.send_byte(8'h58);
        repeat (5) @(negedge core_clk);
        `CHECK(cont_read, 1'b0); // exit while ready low
        // Forty ones in continuous read reset everything
        host_serial_model_inst.send_byte(8'h5c);
        repeat (5) host_serial_model_inst.send_byte(8'hff);
        repeat (5) @(negedge core_clk);
        exp_ch = 2'h0;
        `CHECK({cont_read, status, active_ch}, {1'b0, 8'h80, 2'h0}); // full reset
        // settle time before the next access
        repeat (50000) @(negedge core_clk);
        pol = 1'b0;
        conv(24'h0c0ffe);
        wait_rdy();
        cmd_read(24, w);
        `CHECK(w[23:0], 24'h8c0ffe); // bipolar after reset
        wrap_up();
    end
endmodule

// file: testbench/host_serial_model.sv
// Host serial master model: drives clock, select and data in, samples data out.
// Assumes the block synchronises SCLK and samples DIN on its rising edge.
`timescale 1ns/1ps
module host_serial_model (
    output logic sclk, // Serial clock, idles high
    output logic cs_n, // Chip select, active low
    output logic din, // Host data to block
    input wire logic dout_rdy_n // Data out and ready from block
);
    localparam real HALF_NS = 62.5;

    // Idle levels at time zero
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
    end

    // Select level, then half a period to settle
    task automatic select(input logic on);
        cs_n = ~on;
        #(HALF_NS);
    endtask

    // command first, MSB first
    // Data changes with the low phase so it is stable across the synchronised rise
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sclk = 1'b0;
            din = b[i];
            #(HALF_NS);
            sclk = 1'b1;
            #(HALF_NS);
        end
        din = 1'b0;
    endtask

    // Bits taken at the rising edge, long after the block's update
    task automatic read_word(input int n, output logic [31:0] w);
        w = '0;
        for (int i = 0; i < n; i++) begin
            sclk = 1'b0;
            #(HALF_NS);
            w = {w[30:0], dout_rdy_n};
            sclk = 1'b1;
            #(HALF_NS);
        end
    endtask
endmodule
